// file: core/ldsc_regs.vh
/*
 Register map, field positions, reset values and codes for the
 regulator sleep and control register block.
 Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef LDSC_REGS_VH
`define LDSC_REGS_VH

// Register indices; byte address is four times the index
`define LDSC_IDX_REG1_SLEEP 16'h406A
`define LDSC_IDX_REG2_CTRL 16'h406B
`define LDSC_IDX_REG2_SETTING 16'h4080
`define LDSC_IDX_IRQ_STATUS 16'h4081
`define LDSC_IDX_IRQ_MASK 16'h4082
`define LDSC_IDX_STATE 16'h4083

// Reset values and writable bit masks
`define LDSC_RST_REG1_SLEEP 32'h00000100
`define LDSC_MSK_REG1_SLEEP 32'h0000E11F
`define LDSC_RST_REG2_CTRL 32'h00000200
`define LDSC_MSK_REG2_CTRL 32'h0000DFC1
`define LDSC_RST_REG2_SETTING 32'h01000000
`define LDSC_MSK_REG2_SETTING 32'h011F011F
`define LDSC_MSK_IRQ 32'h00000007

// Regulator one sleep register fields
`define LDSC_R1_SLOT_HI 15
`define LDSC_R1_SLOT_LO 13
`define LDSC_R1_MODE_BIT 8
`define LDSC_R1_VCODE_HI 4
`define LDSC_R1_VCODE_LO 0

// Regulator two control register fields
`define LDSC_R2_UVACT_HI 15
`define LDSC_R2_UVACT_LO 14
`define LDSC_R2_SRC_HI 12
`define LDSC_R2_SRC_LO 11
`define LDSC_R2_HWVSEL_BIT 10
`define LDSC_R2_HWMODE_HI 9
`define LDSC_R2_HWMODE_LO 8
`define LDSC_R2_FLOAT_BIT 7
`define LDSC_R2_SWITCH_BIT 6
`define LDSC_R2_LPLVL_BIT 0

// Regulator two setting register fields
`define LDSC_S2_ONV_HI 4
`define LDSC_S2_ONV_LO 0
`define LDSC_S2_ONMODE_BIT 8
`define LDSC_S2_SLPV_HI 20
`define LDSC_S2_SLPV_LO 16
`define LDSC_S2_SLPMODE_BIT 24

// Interrupt status bit positions
`define LDSC_IRQ_UV_BIT 0
`define LDSC_IRQ_SLEEP_BIT 1
`define LDSC_IRQ_DIS_BIT 2

// Undervoltage actions and hardware control modes
`define LDSC_UV_IGNORE 2'h0
`define LDSC_UV_SHUT_REG 2'h1
`define LDSC_UV_SHUT_SYS 2'h2
`define LDSC_HWM_OFF 2'h1
`define LDSC_HWM_ON_MODE 2'h3

// Sleep voltage decode in millivolts
`define LDSC_V_BASE_MV 12'd900
`define LDSC_V_STEP_LO_MV 12'd50
`define LDSC_V_KNEE_CODE 5'h0F
`define LDSC_V_KNEE_MV 12'd1700
`define LDSC_V_STEP_HI_MV 12'd100

`endif

// file: core/ldsc_vdecode.v
/*
 Piecewise decode of a 5-bit regulator voltage code to millivolts.
 Assumes a registered consumer; the decode is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

module ldsc_vdecode
(
   input wire [4:0] vcode,
   output reg [11:0] millivolts
);

   // Fine steps below the knee, coarse steps from the knee upward
   always @*
   begin
      if (vcode < `LDSC_V_KNEE_CODE)
      begin
         millivolts = `LDSC_V_BASE_MV + `LDSC_V_STEP_LO_MV * {7'h00, vcode};
      end
      else
      begin
         millivolts = `LDSC_V_KNEE_MV
            + `LDSC_V_STEP_HI_MV * {7'h00, vcode - `LDSC_V_KNEE_CODE};
      end
   end

endmodule
`default_nettype wire

// file: core/ldsc_top.v
/*
 APB register block controlling the sleep behaviour of regulator one
 and the general control of regulator two, with sticky interrupts.
 Assumes the sequencer inputs run on pclk; hardware control and
 undervoltage inputs are asynchronous pins and are synchronised here.
*/
// The APB interface to the registers is this design's own decision.
// How it works
// - Slot code 110 applies sleep settings in timeslot 3, 111 in timeslot 1.
// - With hardware enable, codes 001-101 pick the sleep-entry timeslot instead.
// - Code 000 transitions in timeslot 5; 001-101 disable in slots 5 down to 1.
// - Sleep mode bit 8: 0 normal, 1 low power; resets to 1.
// - Sleep voltage code bits 4:0, reset 0, 0.90V plus 50mV steps.
// - Code 0Eh is 1.60V, 0Fh 1.70V, then 100mV steps to 3.30V.
// - Undervoltage action: ignore, shut regulator, shut system with reset.
// - Every undervoltage event raises an interrupt, whatever the action.
// - Hardware source: none, input 1, input 2, or either input.
// - Under hardware control bit 10 picks ON or sleep voltage code.
// - Hardware mode: 00/10 low power, 01 off, 11 ON mode; reset 10.
// - Bit 7 floats or discharges a disabled output; bit 6 selects switch.
// - Bit 0 picks 50mA or 20mA low-power level in every state.
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"

module ldsc_top
#(
   parameter ADDR_W = 20
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire seq_sleep_entry,
   input wire seq_slot_pulse,
   input wire [2:0] seq_slot_num,
   input wire reg1_hw_enable_assigned,
   input wire reg2_sleep_state,
   input wire hw_ctrl1_pin,
   input wire hw_ctrl2_pin,
   input wire reg2_uv_pin,
   output reg reg1_sleep_applied_r,
   output reg reg1_disabled_r,
   output reg reg1_sleep_low_power_r,
   output reg [11:0] reg1_sleep_mv_r,
   output reg [4:0] reg2_vcode_r,
   output reg [11:0] reg2_mv_r,
   output reg reg2_low_power_r,
   output reg reg2_off_r,
   output reg reg2_output_float_r,
   output reg reg2_switch_select_r,
   output reg reg2_low_power_level_r,
   output reg sys_reset_req_r,
   output reg irq_r
);

   reg [31:0] reg1_sleep_r;
   reg [31:0] reg2_ctrl_r;
   reg [31:0] reg2_setting_r;
   reg [2:0] irq_status_r;
   reg [31:0] irq_mask_r;
   reg [31:0] rd_nxt;
   reg hit_nxt;
   reg [2:0] target_slot;
   reg slot_is_disable;
   reg [2:0] hw1_sync_r;
   reg [2:0] hw2_sync_r;
   reg [2:0] uv_sync_r;
   reg hw1_r;
   reg hw2_r;
   reg uv_r;
   reg uv_prev_r;
   reg reg2_uv_shut_r;
   reg [4:0] r2_vcode_nxt;
   reg r2_lp_nxt;
   reg r2_off_nxt;
   reg hw_active;
   wire [ADDR_W-3:0] widx;
   wire access;
   wire wr_en;
   wire [2:0] r1_slot;
   wire [1:0] uv_action;
   wire [1:0] hw_src;
   wire [1:0] hw_mode;
   wire uv_rise;
   wire [2:0] irq_events;
   wire [31:0] irq_w1c;
   wire [11:0] r1_mv;
   wire [11:0] r2_mv;

   // Word index of the access; the low two address bits are ignored
   assign widx = paddr[ADDR_W-1:2];
   assign access = psel & penable;
   assign wr_en = access & pwrite & pready;

   assign r1_slot = reg1_sleep_r[`LDSC_R1_SLOT_HI:`LDSC_R1_SLOT_LO];
   assign uv_action = reg2_ctrl_r[`LDSC_R2_UVACT_HI:`LDSC_R2_UVACT_LO];
   assign hw_src = reg2_ctrl_r[`LDSC_R2_SRC_HI:`LDSC_R2_SRC_LO];
   assign hw_mode = reg2_ctrl_r[`LDSC_R2_HWMODE_HI:`LDSC_R2_HWMODE_LO];

   // Read mux and decode; unmapped addresses answer with an error
   always @*
   begin
      rd_nxt = 32'h00000000;
      hit_nxt = 1'b1;
      case (widx)
         `LDSC_IDX_REG1_SLEEP: rd_nxt = reg1_sleep_r;
         `LDSC_IDX_REG2_CTRL: rd_nxt = reg2_ctrl_r;
         `LDSC_IDX_REG2_SETTING: rd_nxt = reg2_setting_r;
         `LDSC_IDX_IRQ_STATUS: rd_nxt = {29'h0, irq_status_r};
         `LDSC_IDX_IRQ_MASK: rd_nxt = irq_mask_r;
         `LDSC_IDX_STATE: rd_nxt = {12'h000, hw_active, reg2_uv_shut_r,
            hw2_r, hw1_r, reg2_off_r, reg2_low_power_r, reg2_vcode_r,
            6'h00, reg1_sleep_low_power_r, reg1_disabled_r,
            reg1_sleep_applied_r};
         default:
         begin
            hit_nxt = 1'b0;
         end
      endcase
   end

   // One wait state: pready rises in the second access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~hit_nxt;
         if (access & ~pready & ~pwrite)
         begin
            prdata <= rd_nxt;
         end
      end
   end

   // Software registers; reserved bits are never stored
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg1_sleep_r <= `LDSC_RST_REG1_SLEEP;
         reg2_ctrl_r <= `LDSC_RST_REG2_CTRL;
         reg2_setting_r <= `LDSC_RST_REG2_SETTING;
         irq_mask_r <= 32'h00000000;
      end
      else if (wr_en)
      begin
         case (widx)
            `LDSC_IDX_REG1_SLEEP: reg1_sleep_r <= pwdata & `LDSC_MSK_REG1_SLEEP;
            `LDSC_IDX_REG2_CTRL: reg2_ctrl_r <= pwdata & `LDSC_MSK_REG2_CTRL;
            `LDSC_IDX_REG2_SETTING: reg2_setting_r <= pwdata & `LDSC_MSK_REG2_SETTING;
            `LDSC_IDX_IRQ_MASK: irq_mask_r <= pwdata & `LDSC_MSK_IRQ;
            default:
            begin
               irq_mask_r <= irq_mask_r;
            end
         endcase
      end
   end

   // Pin synchronisers; a change counts once stages two and three agree
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hw1_sync_r <= 3'h0;
         hw2_sync_r <= 3'h0;
         uv_sync_r <= 3'h0;
         hw1_r <= 1'b0;
         hw2_r <= 1'b0;
         uv_r <= 1'b0;
         uv_prev_r <= 1'b0;
      end
      else
      begin
         hw1_sync_r <= {hw1_sync_r[1:0], hw_ctrl1_pin};
         hw2_sync_r <= {hw2_sync_r[1:0], hw_ctrl2_pin};
         uv_sync_r <= {uv_sync_r[1:0], reg2_uv_pin};
         if (hw1_sync_r[1] == hw1_sync_r[2])
         begin
            hw1_r <= hw1_sync_r[2];
         end
         if (hw2_sync_r[1] == hw2_sync_r[2])
         begin
            hw2_r <= hw2_sync_r[2];
         end
         if (uv_sync_r[1] == uv_sync_r[2])
         begin
            uv_r <= uv_sync_r[2];
         end
         uv_prev_r <= uv_r;
      end
   end

   assign uv_rise = uv_r & ~uv_prev_r;

   // Timeslot target and action of the regulator one sleep slot code
   always @*
   begin
      slot_is_disable = 1'b1;
      case (r1_slot)
         3'h0:
         begin
            target_slot = 3'h5;
            slot_is_disable = 1'b0;
         end
         3'h1: target_slot = 3'h5;
         3'h2: target_slot = 3'h4;
         3'h3: target_slot = 3'h3;
         3'h4: target_slot = 3'h2;
         3'h5: target_slot = 3'h1;
         3'h6:
         begin
            target_slot = 3'h3;
            slot_is_disable = 1'b0;
         end
         3'h7:
         begin
            target_slot = 3'h1;
            slot_is_disable = 1'b0;
         end
         default:
         begin
            target_slot = 3'h5;
         end
      endcase
      // A hardware-enabled regulator sleeps rather than turns off
      if (reg1_hw_enable_assigned)
      begin
         slot_is_disable = 1'b0;
      end
   end

   // Regulator one sleep sequencing; leaving sleep entry restores it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg1_sleep_applied_r <= 1'b0;
         reg1_disabled_r <= 1'b0;
      end
      else if (!seq_sleep_entry)
      begin
         reg1_sleep_applied_r <= 1'b0;
         reg1_disabled_r <= 1'b0;
      end
      else if (seq_slot_pulse && seq_slot_num == target_slot)
      begin
         reg1_sleep_applied_r <= ~slot_is_disable;
         reg1_disabled_r <= slot_is_disable;
      end
   end

   // Sleep mode and voltage are published as soon as they are written
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg1_sleep_low_power_r <= 1'b1;
         reg1_sleep_mv_r <= `LDSC_V_BASE_MV;
      end
      else
      begin
         reg1_sleep_low_power_r <= reg1_sleep_r[`LDSC_R1_MODE_BIT];
         reg1_sleep_mv_r <= r1_mv;
      end
   end

   ldsc_vdecode u_r1_dec
   (
      .vcode(reg1_sleep_r[`LDSC_R1_VCODE_HI:`LDSC_R1_VCODE_LO]),
      .millivolts(r1_mv)
   );

   // Regulator two applied setting: hardware control over software
   always @*
   begin
      case (hw_src)
         2'h1: hw_active = hw1_r;
         2'h2: hw_active = hw2_r;
         2'h3: hw_active = hw1_r | hw2_r;
         default: hw_active = 1'b0;
      endcase
      r2_off_nxt = reg2_uv_shut_r;
      if (hw_active)
      begin
         if (reg2_ctrl_r[`LDSC_R2_HWVSEL_BIT])
         begin
            r2_vcode_nxt = reg2_setting_r[`LDSC_S2_SLPV_HI:`LDSC_S2_SLPV_LO];
         end
         else
         begin
            r2_vcode_nxt = reg2_setting_r[`LDSC_S2_ONV_HI:`LDSC_S2_ONV_LO];
         end
         if (hw_mode == `LDSC_HWM_ON_MODE)
         begin
            r2_lp_nxt = reg2_setting_r[`LDSC_S2_ONMODE_BIT];
         end
         else
         begin
            r2_lp_nxt = (hw_mode != `LDSC_HWM_OFF);
         end
         if (hw_mode == `LDSC_HWM_OFF)
         begin
            r2_off_nxt = 1'b1;
         end
      end
      else if (reg2_sleep_state)
      begin
         r2_vcode_nxt = reg2_setting_r[`LDSC_S2_SLPV_HI:`LDSC_S2_SLPV_LO];
         r2_lp_nxt = reg2_setting_r[`LDSC_S2_SLPMODE_BIT];
      end
      else
      begin
         r2_vcode_nxt = reg2_setting_r[`LDSC_S2_ONV_HI:`LDSC_S2_ONV_LO];
         r2_lp_nxt = reg2_setting_r[`LDSC_S2_ONMODE_BIT];
      end
   end

   ldsc_vdecode u_r2_dec
   (
      .vcode(r2_vcode_nxt),
      .millivolts(r2_mv)
   );

   // Registered regulator two controls
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg2_vcode_r <= 5'h00;
         reg2_mv_r <= `LDSC_V_BASE_MV;
         reg2_low_power_r <= 1'b0;
         reg2_off_r <= 1'b0;
         reg2_output_float_r <= 1'b0;
         reg2_switch_select_r <= 1'b0;
         reg2_low_power_level_r <= 1'b0;
      end
      else
      begin
         reg2_vcode_r <= r2_vcode_nxt;
         reg2_mv_r <= r2_mv;
         reg2_low_power_r <= r2_lp_nxt;
         reg2_off_r <= r2_off_nxt;
         reg2_output_float_r <= reg2_ctrl_r[`LDSC_R2_FLOAT_BIT];
         reg2_switch_select_r <= reg2_ctrl_r[`LDSC_R2_SWITCH_BIT];
         reg2_low_power_level_r <= reg2_ctrl_r[`LDSC_R2_LPLVL_BIT];
      end
   end

   // Undervoltage action; the shutdown holds until the status is cleared
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg2_uv_shut_r <= 1'b0;
         sys_reset_req_r <= 1'b0;
      end
      else
      begin
         sys_reset_req_r <= uv_rise && uv_action == `LDSC_UV_SHUT_SYS;
         if (uv_rise && uv_action == `LDSC_UV_SHUT_REG)
         begin
            reg2_uv_shut_r <= 1'b1;
         end
         else if (!irq_status_r[`LDSC_IRQ_UV_BIT])
         begin
            reg2_uv_shut_r <= 1'b0;
         end
      end
   end

   // Sticky status bits; a new event beats a clear in the same cycle
   assign irq_events = {seq_slot_pulse & seq_sleep_entry & slot_is_disable
         & seq_slot_num == target_slot,
      seq_slot_pulse & seq_sleep_entry & ~slot_is_disable
         & seq_slot_num == target_slot,
      uv_rise};
   assign irq_w1c = (wr_en && widx == `LDSC_IDX_IRQ_STATUS) ? pwdata : 32'h00000000;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_irq
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               irq_status_r[gi] <= 1'b0;
            end
            else if (irq_events[gi])
            begin
               irq_status_r[gi] <= 1'b1;
            end
            else if (irq_w1c[gi])
            begin
               irq_status_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Level interrupt; registered, so it trails the status by one cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(irq_status_r & irq_mask_r[2:0]);
      end
   end

endmodule
`default_nettype wire

// file: verif/ldsc_top_assertions.sv
/*
 Concurrent checks on the APB slave and regulator outputs of ldsc_top.
 Assumes a bind to ldsc_top, one clock pclk and async reset presetn.
*/
`timescale 1ns/1ps
`default_nettype none
module ldsc_top_chk
#(
   parameter ADDR_W = 20
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic seq_sleep_entry,
   input wire logic seq_slot_pulse,
   input wire logic reg1_sleep_applied_r,
   input wire logic reg1_disabled_r,
   input wire logic [11:0] reg1_sleep_mv_r,
   input wire logic sys_reset_req_r
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Exactly one wait state after the first access cycle
   a_ready_one_wait:
      assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready missing one cycle after access start");
   a_ready_single:
      assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause:
      assert property (pready |-> $past(psel && penable))
      else $error("pready without a pending access");
   a_err_with_ready:
      assert property (pslverr |-> pready)
      else $error("pslverr outside an answer");
   a_err_reads_zero:
      assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned nonzero data");
   // Sleep outcomes only follow a sequencer timeslot
   a_sleep_cause:
      assert property ($rose(reg1_sleep_applied_r) |-> $past(seq_slot_pulse && seq_sleep_entry))
      else $error("sleep applied without a timeslot");
   a_disable_cause:
      assert property ($rose(reg1_disabled_r) |-> $past(seq_slot_pulse) && !reg1_sleep_applied_r)
      else $error("disable without a timeslot or with sleep");
   a_sleep_release:
      assert property (!seq_sleep_entry |=> !reg1_sleep_applied_r && !reg1_disabled_r)
      else $error("sleep outputs kept after sleep entry ended");
   a_sleep_mv_range:
      assert property (reg1_sleep_mv_r >= 12'd900 && reg1_sleep_mv_r <= 12'd3300)
      else $error("sleep voltage outside decode range");
   a_sysrst_pulse:
      assert property (sys_reset_req_r |=> !sys_reset_req_r)
      else $error("system reset request longer than a pulse");
endmodule
`default_nettype wire

// file: verif/ldo_sleep_and_control_regs_tb_top.sv
/*
 Self-checking bench for ldsc_top: registers, timeslots, pins, irq.
 Assumes the register header on the include path and a 25 MHz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ldsc_regs.vh"
module ldo_sleep_and_control_regs_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_r;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic seq_sleep_entry, seq_slot_pulse, reg1_hw_enable_assigned, reg2_sleep_state;
   logic [2:0] seq_slot_num;
   logic hw_ctrl1_pin, hw_ctrl2_pin, reg2_uv_pin, sys_reset_req_r, reg2_off_r;
   logic reg1_sleep_applied_r, reg1_disabled_r, reg1_sleep_low_power_r, reg2_low_power_r;
   logic reg2_output_float_r, reg2_switch_select_r, reg2_low_power_level_r;
   logic [11:0] reg1_sleep_mv_r, reg2_mv_r;
   logic [4:0] reg2_vcode_r;
   logic [32:0] rq[$];
   logic [4:0] tbl [4] = '{5'h00, 5'h0E, 5'h0F, 5'h1F};
   int errors, tests_run, n_rst;

   ldsc_top #(.ADDR_W(20)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .seq_sleep_entry, .seq_slot_pulse, .seq_slot_num,
      .reg1_hw_enable_assigned, .reg2_sleep_state, .hw_ctrl1_pin, .hw_ctrl2_pin, .reg2_uv_pin,
      .reg1_sleep_applied_r, .reg1_disabled_r, .reg1_sleep_low_power_r, .reg1_sleep_mv_r,
      .reg2_vcode_r, .reg2_mv_r, .reg2_low_power_r, .reg2_off_r, .reg2_output_float_r,
      .reg2_switch_select_r, .reg2_low_power_level_r, .sys_reset_req_r, .irq_r);

   // Free-running 25 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Piecewise decode: fine steps up to 0Eh, coarse steps from 0Fh
   function automatic logic [11:0] mv(input logic [4:0] c);
      return (c < 5'h0F) ? 12'd900 + 12'd50 * c : 12'd1700 + 12'd100 * (c - 5'h0F);
   endfunction

   task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; waits on pready, only the watchdog ends a hang
   task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] i, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, i, 32'h0);
   endtask

   // One-cycle timeslot pulse; returns mid-cycle after the taking edge
   task automatic slot(input logic [2:0] s);
      @(posedge pclk);
      seq_slot_pulse <= 1'b1;
      seq_slot_num <= s;
      @(posedge pclk);
      seq_slot_pulse <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic report_and_stop();
      $display("Checks run %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Read answers are matched against notes in order of issue
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (rq.size() == 0)
            cmp("unexpected_read", 33'h0, 33'h1);
         else
            cmp("prdata", rq.pop_front(), {pslverr, prdata});
      end
   end

   // Count system reset pulses
   always @(posedge pclk)
   begin
      if (sys_reset_req_r === 1'b1)
         n_rst++;
   end

   // Watchdog, far beyond the expected run length
   initial
   begin
      repeat (30000) @(posedge pclk);
      errors++;
      report_and_stop();
   end

   initial
   begin
      logic [31:0] r;
      logic [2:0] cd, tg, src;
      logic [1:0] hm;
      logic [4:0] vc;
      logic dis, act, lp, off;
      int k;
      {presetn, psel, penable, pwrite, paddr, pwdata, seq_sleep_entry, seq_slot_pulse} = '0;
      {seq_slot_num, reg1_hw_enable_assigned, reg2_sleep_state} = '0;
      {hw_ctrl1_pin, hw_ctrl2_pin, reg2_uv_pin} = '0;
      seed = 32'h394E;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      cmp("sleep_lp_rst", 1, reg1_sleep_low_power_r);
      cmp("sleep_mv_rst", 900, reg1_sleep_mv_r);
      rd(`LDSC_IDX_REG1_SLEEP, {1'b0, 32'h00000100});
      rd(`LDSC_IDX_REG2_CTRL, {1'b0, 32'h00000200});
      rd(`LDSC_IDX_REG2_SETTING, {1'b0, 32'h01000000});
      rd(16'h4090, {1'b1, 32'h0});
      apb(1'b1, `LDSC_IDX_REG1_SLEEP, 32'hFFFFFFFF);
      rd(`LDSC_IDX_REG1_SLEEP, {1'b0, 32'h0000E11F});
      apb(1'b1, `LDSC_IDX_IRQ_MASK, 32'h7);
      rd(`LDSC_IDX_IRQ_MASK, {1'b0, 32'h00000007});
      // Every slot code, with and without a hardware enable
      for (int c = 0; c < 16; c++)
      begin
         r = xs();
         if (c < 4)
            r[4:0] = tbl[c];
         cd = c[2:0];
         tg = (cd == 0) ? 3'd5 : (cd <= 5) ? 3'd6 - cd : (cd == 6) ? 3'd3 : 3'd1;
         dis = (cd >= 1 && cd <= 5 && !c[3]);
         reg1_hw_enable_assigned <= c[3];
         apb(1'b1, `LDSC_IDX_REG1_SLEEP, {16'h0, cd, 4'h0, r[8], 3'h0, r[4:0]});
         seq_sleep_entry <= 1'b1;
         slot((tg == 3'd5) ? 3'd1 : tg + 3'd1);
         cmp("stray_slot", 0, {reg1_sleep_applied_r, reg1_disabled_r});
         slot(tg);
         cmp("slot_outcome", {!dis, dis}, {reg1_sleep_applied_r, reg1_disabled_r});
         cmp("sleep_lp", r[8], reg1_sleep_low_power_r);
         cmp("sleep_mv", mv(r[4:0]), reg1_sleep_mv_r);
         @(negedge pclk);
         cmp("irq_event", 1, irq_r);
         apb(1'b1, `LDSC_IDX_IRQ_STATUS, 32'h7);
         seq_sleep_entry <= 1'b0;
         repeat (2) @(negedge pclk);
         cmp("irq_clear", 0, irq_r);
         cmp("sleep_release", 0, {reg1_sleep_applied_r, reg1_disabled_r});
      end
      // Undervoltage under each action code, the reserved one masked
      for (int a = 0; a < 4; a++)
      begin
         k = n_rst;
         if (a == 3)
            apb(1'b1, `LDSC_IDX_IRQ_MASK, 32'h0);
         apb(1'b1, `LDSC_IDX_REG2_CTRL, {16'h0, a[1:0], 14'h0200});
         reg2_uv_pin <= 1'b1;
         repeat (8) @(negedge pclk);
         cmp("uv_irq", a < 3, irq_r);
         cmp("uv_shutdown", a == 1, reg2_off_r);
         cmp("uv_sys_reset", a == 2, n_rst - k);
         rd(`LDSC_IDX_IRQ_STATUS, {1'b0, 32'h1});
         reg2_uv_pin <= 1'b0;
         apb(1'b1, `LDSC_IDX_IRQ_STATUS, 32'h1);
         repeat (8) @(negedge pclk);
         cmp("uv_clear", 0, {irq_r, reg2_off_r});
      end
      // Hardware control sources, modes and voltage choice
      for (int i = 0; i < 32; i++)
      begin
         r = xs();
         hm = i[3:2];
         src = {1'b0, i[1:0]};
         apb(1'b1, `LDSC_IDX_REG2_SETTING, {7'h0, 1'b1, 3'h0, 5'h1C, 7'h0, r[9], 3'h0, 5'h03});
         apb(1'b1, `LDSC_IDX_REG2_CTRL, {16'h0, 3'h0, src[1:0], r[10], hm, r[7:6], 5'h0, r[0]});
         hw_ctrl1_pin <= r[1];
         hw_ctrl2_pin <= r[2];
         reg2_sleep_state <= r[3];
         act = (src[0] & r[1]) | (src[1] & r[2]);
         vc = (act ? r[10] : r[3]) ? 5'h1C : 5'h03;
         lp = act ? ((hm == 2'h3) ? r[9] : 1'b1) : (r[3] ? 1'b1 : r[9]);
         off = act && hm == 2'h1;
         repeat (8) @(negedge pclk);
         cmp("reg2_off", off, reg2_off_r);
         if (!off)
         begin
            cmp("reg2_vcode", vc, reg2_vcode_r);
            cmp("reg2_mv", mv(vc), reg2_mv_r);
            cmp("reg2_lp", lp, reg2_low_power_r);
         end
         cmp("reg2_bits", {r[7:6], r[0]}, {reg2_output_float_r, reg2_switch_select_r,
            reg2_low_power_level_r});
      end
      report_and_stop();
   end
endmodule

bind ldsc_top ldsc_top_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .seq_sleep_entry(seq_sleep_entry), .seq_slot_pulse(seq_slot_pulse),
   .reg1_sleep_applied_r(reg1_sleep_applied_r), .reg1_disabled_r(reg1_disabled_r),
   .reg1_sleep_mv_r(reg1_sleep_mv_r), .sys_reset_req_r(sys_reset_req_r));
`default_nettype wire
